/* core/pmcs_top.sv */
// Port operating mode change sequencer with APB registers
`timescale 1ns/10ps
`include "pmcs_consts.svh"
module pmcs_top #(
  parameter int NPORT     = 4,
  parameter int NPART     = 4,
  parameter int TW        = 16,
  parameter int NOACT_CYC = `PMCS_NOACT_CYC,
  parameter int RESET_CYC = `PMCS_RESET_CYC
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire pmcs_pkg::pmcs_apb_req_s apb_req,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NPORT-1:0]     hot_reset_req,
  input  wire logic [NPORT-1:0]     l0s_rx_exit,
  output logic [NPORT-1:0]          port_attached,
  output logic [NPORT-1:0]          port_is_up,
  output logic [NPART-1:0]          part_has_up,
  output logic [NPART-1:0]          part_hot_reset,
  output logic [NPORT-1:0]          port_hot_reset,
  output logic [NPART-1:0]          part_sec_reset,
  output logic [NPORT-1:0]          port_sec_reset,
  output logic [NPORT-1:0]          port_below_reset,
  output logic                      route_inval,
  output logic [1:0]                route_inval_port,
  output logic [1:0]                route_inval_part,
  output logic [NPORT-1:0]          port_action_reset,
  output logic [NPART-1:0]          l0s_tx_exit_up,
  output logic                      mode_change_started,
  output logic                      mode_change_done
);
  import pmcs_pkg::*;

  pmcs_state_e state;                       // Sequencer state
  pmcs_port_s  cfg [NPORT];                 // Live per-port configuration
  pmcs_port_s  pend;                        // Configuration being applied
  logic        pend_reset;                  // Action is reset
  logic [1:0]  sel;                         // Port being changed
  logic [31:0] ctrl;                        // Last control word accepted while idle
  logic [NPORT-1:0] attached;               // Port is partition member
  logic [NPORT-1:0] sbr;                    // Secondary bus reset bits
  logic        expired;                     // Latency elapsed
  logic        setup;                       // APB setup phase
  logic        access;                      // APB access completing
  logic        wr;                          // Accepted write
  logic        go;                          // Control write starts change
  logic [31:0] rdata;                       // Read mux
  logic [NPORT-1:0] dn_member;              // Attached downstream ports
  logic [NPORT-1:0][1:0] part_of;           // Partition of each port
  logic [NPART-1:0] next_part_hr;           // Partition hot reset
  logic [NPART-1:0] next_part_sr;           // Partition bus reset
  logic [NPART-1:0] next_has_up;            // Partition has upstream
  logic [NPORT-1:0] next_port_hr;           // Port in hot reset
  logic [NPORT-1:0] next_port_sr;           // Port in bus reset
  logic [NPORT-1:0] next_below;             // Reset below a port
  logic [NPORT-1:0] next_is_up;             // Attached upstream ports

  // Address decode for the error path
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `PMCS_OFF_CTRL) || (a == `PMCS_OFF_STATUS) ||
             (a == `PMCS_OFF_PORTINFO) || (a == `PMCS_OFF_SBR) ||
             (a == `PMCS_OFF_PART);
  endfunction : mapped

  // Software write-one-to-clear decode of one status bit
  function automatic logic sts_w1c(input logic w, input logic [7:0] a, input logic d);
    sts_w1c = w && (a == `PMCS_OFF_STATUS) && d;
  endfunction : sts_w1c

  // APB phase qualifiers
  assign setup  = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable && pready;
  assign wr     = access && apb_req.pwrite && !pslverr;
  assign go     = wr && (apb_req.paddr == `PMCS_OFF_CTRL);

  // Read data selection
  always_comb begin
    rdata = 32'h0000_0000;
    case (apb_req.paddr)
      `PMCS_OFF_CTRL: begin
        rdata = ctrl;
      end
      `PMCS_OFF_STATUS: begin
        rdata = {25'h000_0000, state, 1'b0, (state != ST_IDLE),
                 mode_change_done, mode_change_started};
      end
      `PMCS_OFF_PORTINFO: begin
        rdata = {22'h00_0000, attached[ctrl[13:12]], cfg[ctrl[13:12]]};
      end
      `PMCS_OFF_SBR: begin
        rdata = {28'h000_0000, sbr};
      end
      `PMCS_OFF_PART: begin
        rdata = {20'h0_0000, part_sec_reset, part_hot_reset, part_has_up};
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end

  // APB slave: one wait-free access, answer loaded in setup
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      // Zero wait states: the answer always stands in the cycle after setup
      pready <= setup;
      if (setup) begin
        prdata  <= rdata;
        pslverr <= !mapped(apb_req.paddr);
      end else if (access) begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control word and secondary bus reset bits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl <= `PMCS_CTRL_RST;
      sbr  <= `PMCS_SBR_RST;
    end else if (wr) begin
      // Changes while busy are ignored, software must wait
      if (go && state == ST_IDLE) begin
        ctrl <= apb_req.pwdata;
      end
      if (apb_req.paddr == `PMCS_OFF_SBR) begin
        sbr <= apb_req.pwdata[NPORT-1:0];
      end
    end
  end

  // Sequencer: started, remove, add, action, done
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      pend       <= '0;
      pend_reset <= 1'b0;
      sel        <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            pend.mode   <= pmcs_mode_e'(apb_req.pwdata[`PMCS_CTRL_MODE_LO +: 2]);
            pend.part   <= apb_req.pwdata[`PMCS_CTRL_PART_LO +: 2];
            pend.devnum <= apb_req.pwdata[`PMCS_CTRL_DEVNUM_LO +: 5];
            pend_reset  <= apb_req.pwdata[`PMCS_CTRL_ACTION_BIT];
            sel         <= apb_req.pwdata[`PMCS_CTRL_SEL_LO +: 2];
            state       <= ST_START;
          end
        end
        ST_START: begin
          state <= ST_REMOVE;
        end
        ST_REMOVE: begin
          // Always a full removal, even for the same partition
          state <= ST_ADD;
        end
        ST_ADD: begin
          state <= ST_ACTION;
        end
        ST_ACTION: begin
          // Wait out the latency of the chosen action
          if (expired) begin
            state <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Latency timer, loaded when the change starts
  // Expiry is cleared on start, so the action wait never sees a stale flag
  pmcs_timer #(
    .W (TW)
  ) u_timer (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (state == ST_START),
    .cycles  (pend_reset ? TW'(RESET_CYC) : TW'(NOACT_CYC)),
    .expired (expired)
  );

  // Status flags; hardware set wins over software clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_change_started <= 1'b0;
      mode_change_done    <= 1'b0;
    end else begin
      if (state == ST_START) begin
        mode_change_started <= 1'b1;
      end else if (sts_w1c(wr, apb_req.paddr, apb_req.pwdata[`PMCS_STS_STARTED_BIT])) begin
        // Clear only when no new change starts in the same cycle
        mode_change_started <= 1'b0;
      end
      if (state == ST_FINISH) begin
        mode_change_done <= 1'b1;
      end else if (state == ST_START ||
                   sts_w1c(wr, apb_req.paddr, apb_req.pwdata[`PMCS_STS_DONE_BIT])) begin
        // A new change or a software clear retires the old completion
        mode_change_done <= 1'b0;
      end
    end
  end

  // Membership and port configuration
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      attached <= '0;
      for (int i = 0; i < NPORT; i++) begin
        cfg[i] <= '0;
      end
    end else if (state == ST_REMOVE) begin
      attached[sel] <= 1'b0;
    end else if (state == ST_ADD) begin
      // Device number and mode updated in the same cycle as the addition
      cfg[sel]      <= pend;
      // Disabled and unattached modes leave the port outside every partition
      attached[sel] <= (pend.mode == MODE_UP) || (pend.mode == MODE_DN);
    end
  end

  // Route invalidation pulse for a removed member
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      route_inval      <= 1'b0;
      route_inval_port <= 2'h0;
      route_inval_part <= 2'h0;
    end else begin
      // Port and partition stay held for software after the pulse
      route_inval <= (state == ST_REMOVE) && attached[sel];
      if (state == ST_REMOVE) begin
        route_inval_port <= sel;
        route_inval_part <= cfg[sel].part;
      end
    end
  end

  // Action on the port itself while the change settles
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_action_reset <= '0;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        port_action_reset[i] <= (state == ST_ACTION) && pend_reset &&
                                (sel == 2'(i));
      end
    end
  end

  // Partition reset and membership views from current members only
  always_comb begin
    next_part_hr = '0;
    next_part_sr = '0;
    next_has_up  = '0;
    // Upstream members alone carry hot and bus reset into a partition
    for (int i = 0; i < NPORT; i++) begin
      part_of[i]    = cfg[i].part;
      next_is_up[i] = attached[i] && (cfg[i].mode == MODE_UP);
      dn_member[i]  = attached[i] && (cfg[i].mode == MODE_DN);
      if (next_is_up[i]) begin
        // A removed upstream port drops out, the partition runs on
        next_has_up[cfg[i].part]  = 1'b1;
        next_part_hr[cfg[i].part] = next_part_hr[cfg[i].part] |
                                    hot_reset_req[i];
        next_part_sr[cfg[i].part] = next_part_sr[cfg[i].part] | sbr[i];
      end
    end
    for (int i = 0; i < NPORT; i++) begin
      next_port_hr[i] = dn_member[i] && next_part_hr[cfg[i].part];
      next_port_sr[i] = dn_member[i] && next_part_sr[cfg[i].part];
      next_below[i]   = dn_member[i] && sbr[i];
    end
  end

  // Registered partition and port status outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_attached    <= '0;
      port_is_up       <= '0;
      part_has_up      <= '0;
      part_hot_reset   <= '0;
      port_hot_reset   <= '0;
      part_sec_reset   <= '0;
      port_sec_reset   <= '0;
      port_below_reset <= '0;
    end else begin
      port_attached    <= attached;
      port_is_up       <= next_is_up;
      part_has_up      <= next_has_up;
      part_hot_reset   <= next_part_hr;
      port_hot_reset   <= next_port_hr;
      part_sec_reset   <= next_part_sr;
      port_sec_reset   <= next_port_sr;
      port_below_reset <= next_below;
    end
  end

  // L0s exit propagation
  // Membership feeds the propagator directly, so a removal acts at once
  pmcs_l0s #(
    .NPORT (NPORT),
    .NPART (NPART)
  ) u_l0s (
    .clock      (clock),
    .rst_n      (rst_n),
    .rx_exit    (l0s_rx_exit),
    .dn_member  (dn_member),
    .part_of    (part_of),
    .tx_exit_up (l0s_tx_exit_up)
  );
endmodule : pmcs_top

/* core/pmcs_consts.svh */
// Offsets, field positions, reset values and timing counts of the mode change sequencer
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH
// Clock rate in MHz
`define PMCS_CLK_MHZ 10
// Latency with no action, in microseconds
`define PMCS_NOACT_US 2000
// Latency with reset action, in microseconds
`define PMCS_RESET_US 2500
// Derived latencies in clock cycles
`define PMCS_NOACT_CYC (`PMCS_NOACT_US * `PMCS_CLK_MHZ)
`define PMCS_RESET_CYC (`PMCS_RESET_US * `PMCS_CLK_MHZ)
// Register byte offsets
`define PMCS_OFF_CTRL 8'h00
`define PMCS_OFF_STATUS 8'h04
`define PMCS_OFF_PORTINFO 8'h08
`define PMCS_OFF_SBR 8'h0C
`define PMCS_OFF_PART 8'h10
// Control register fields
`define PMCS_CTRL_MODE_LO 0
`define PMCS_CTRL_PART_LO 2
`define PMCS_CTRL_DEVNUM_LO 4
`define PMCS_CTRL_ACTION_BIT 9
`define PMCS_CTRL_SEL_LO 12
// Status register fields
`define PMCS_STS_STARTED_BIT 0
`define PMCS_STS_DONE_BIT 1
// Reset values
`define PMCS_CTRL_RST 32'h0000_0000
`define PMCS_SBR_RST 4'h0
`endif

/* core/pmcs_pkg.sv */
// Types shared by the mode change sequencer files
package pmcs_pkg;
  // Port operating modes
  typedef enum logic [1:0] {
    MODE_UNATT = 2'h0,
    MODE_UP    = 2'h1,
    MODE_DN    = 2'h2,
    MODE_DIS   = 2'h3
  } pmcs_mode_e;
  // Sequencer states, Gray coded from idle up to finish
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_START  = 3'h1,
    ST_REMOVE = 3'h3,
    ST_ADD    = 3'h2,
    ST_ACTION = 3'h6,
    ST_FINISH = 3'h7
  } pmcs_state_e;
  // Per-port configuration
  typedef struct packed {
    pmcs_mode_e  mode;
    logic [1:0]  part;
    logic [4:0]  devnum;
  } pmcs_port_s;
  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pmcs_apb_req_s;
endpackage : pmcs_pkg

/* core/pmcs_timer.sv */
// Latency down-counter for one mode change
`timescale 1ns/10ps
module pmcs_timer #(
  parameter int W = 16
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] cycles,
  output logic              expired
);
  import pmcs_pkg::*;
  logic [W-1:0] count;  // Cycles left
  logic         run;    // Counting
  // Load on start, count down, flag expiry until next start
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count   <= '0;
      run     <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      count   <= cycles;
      run     <= 1'b1;
      expired <= 1'b0;
    end else if (run) begin
      if (count <= W'(1)) begin
        run     <= 1'b0;
        expired <= 1'b1;
      end else begin
        count <= count - W'(1);
      end
    end
  end
endmodule : pmcs_timer

/* core/pmcs_l0s.sv */
// L0s exit propagation from downstream receivers to partition upstream transmitters
`timescale 1ns/10ps
module pmcs_l0s #(
  parameter int NPORT = 4,
  parameter int NPART = 4
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [NPORT-1:0]      rx_exit,
  input  wire logic [NPORT-1:0]      dn_member,
  input  wire logic [NPORT-1:0][1:0] part_of,
  output logic [NPART-1:0]           tx_exit_up
);
  import pmcs_pkg::*;
  logic [NPART-1:0] next_tx_exit_up;  // Combined exit requests
  // Only current downstream members may wake their upstream port
  always_comb begin
    next_tx_exit_up = '0;
    for (int i = 0; i < NPORT; i++) begin
      if (dn_member[i] && rx_exit[i]) begin
        next_tx_exit_up[part_of[i]] = 1'b1;
      end
    end
  end
  // Registered request toward each upstream transmitter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_exit_up <= '0;
    end else begin
      tx_exit_up <= next_tx_exit_up;
    end
  end
endmodule : pmcs_l0s

/* verification/pmcs_checker.sv */
// Concurrent checks on the mode change sequencer ports
`timescale 1ns/10ps
module pmcs_checker
  import pmcs_pkg::*;
#(
  parameter int NPORT     = 4,
  parameter int NPART     = 4,
  parameter int NOACT_CYC = 20,
  parameter int RESET_CYC = 25
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic [NPORT-1:0]  hot_reset_req,
  input wire logic [NPORT-1:0]  l0s_rx_exit,
  input wire logic [NPORT-1:0]  port_attached,
  input wire logic [NPORT-1:0]  port_is_up,
  input wire logic [NPART-1:0]  part_has_up,
  input wire logic [NPART-1:0]  part_hot_reset,
  input wire logic [NPORT-1:0]  port_hot_reset,
  input wire logic [NPORT-1:0]  port_sec_reset,
  input wire logic              route_inval,
  input wire logic [1:0]        route_inval_port,
  input wire logic [NPART-1:0]  l0s_tx_exit_up,
  input wire logic              mode_change_started,
  input wire logic              mode_change_done
);
  logic [NPORT-1:0] up_d;  // Upstream members one cycle ago
  logic [NPORT-1:0] att_d; // Members one cycle ago
  logic [15:0]      lat;   // Cycles spent in the running change
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Membership copies, one cycle of slack for flop lag
  always_ff @(posedge clock) begin
    up_d  <= port_is_up;
    att_d <= port_attached;
  end
  // Latency count, cleared when the started flag is clear
  always_ff @(posedge clock) begin
    if (!rst_n || !mode_change_started) begin
      lat <= 16'h0000;
    end else if (!mode_change_done) begin
      lat <= lat + 16'h0001;
    end
  end
  order_start_a: assert property ($rose(mode_change_done) |-> mode_change_started)
    else $error("done rose without started");
  latency_span_a: assert property ($rose(mode_change_done) |->
    lat >= NOACT_CYC && lat <= RESET_CYC + 8) else $error("change latency out of range");
  inval_window_a: assert property (route_inval |-> mode_change_started && !mode_change_done)
    else $error("route invalidation outside a change");
  inval_source_a: assert property (route_inval |-> att_d[route_inval_port])
    else $error("route invalidation for a port that was not attached");
  hot_member_a: assert property ((port_hot_reset & ~(port_attached | att_d)) == '0)
    else $error("removed port still in hot reset");
  sec_member_a: assert property ((port_sec_reset & ~(port_attached | att_d)) == '0)
    else $error("removed port still in bus reset");
  l0s_cause_a: assert property (l0s_tx_exit_up != '0 |->
    $past(|(l0s_rx_exit & (port_attached | att_d) & ~port_is_up)))
    else $error("upstream exit without a member receiver exit");
  hot_cause_a: assert property (part_hot_reset != '0 |->
    $past(|(hot_reset_req & (port_is_up | up_d)))) else $error("hot reset without upstream cause");
  has_up_a: assert property (part_has_up != '0 |-> (port_is_up | up_d) != '0)
    else $error("upstream flag without upstream member");
endmodule : pmcs_checker

bind pmcs_top pmcs_checker #(.NPORT(NPORT), .NPART(NPART), .NOACT_CYC(NOACT_CYC),
  .RESET_CYC(RESET_CYC)) chk_u (.clock(clock), .rst_n(rst_n), .hot_reset_req(hot_reset_req),
  .l0s_rx_exit(l0s_rx_exit), .port_attached(port_attached), .port_is_up(port_is_up),
  .part_has_up(part_has_up), .part_hot_reset(part_hot_reset), .port_hot_reset(port_hot_reset),
  .port_sec_reset(port_sec_reset), .route_inval(route_inval),
  .route_inval_port(route_inval_port), .l0s_tx_exit_up(l0s_tx_exit_up),
  .mode_change_started(mode_change_started), .mode_change_done(mode_change_done));

/* verification/pmcs_tb_top.sv */
// Self-checking bench for the port mode change sequencer
`timescale 1ns/10ps
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module pmcs_tb_top;
  import pmcs_pkg::*;
  logic          clock, rst_n;       // Clock and reset
  pmcs_apb_req_s req;                // APB request
  logic [31:0]   prdata, rq;         // Read data, last captured word
  logic          pready, pslverr, er; // Answer and last error flag
  logic [3:0]    hot_req, rx_exit;   // Hot reset and receiver exit inputs
  logic [3:0]    att, up, has_up, p_hot, hot, p_sec, sec, below, act_rst, tx_up;
  logic          inval, started, done, act_seen;
  logic [1:0]    inval_port, inval_part; // Port and partition of last invalidation
  int            failures, checks_done, lat, lat_r, n_inval, n_tx;
  pmcs_top #(.NOACT_CYC(20), .RESET_CYC(25)) dut_u (
    .clock(clock), .rst_n(rst_n), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hot_reset_req(hot_req), .l0s_rx_exit(rx_exit),
    .port_attached(att), .port_is_up(up), .part_has_up(has_up), .part_hot_reset(p_hot),
    .port_hot_reset(hot), .part_sec_reset(p_sec), .port_sec_reset(sec),
    .port_below_reset(below), .route_inval(inval), .route_inval_port(inval_port),
    .route_inval_part(inval_part), .port_action_reset(act_rst), .l0s_tx_exit_up(tx_up),
    .mode_change_started(started), .mode_change_done(done));
  // Clock at 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Event counters, sampled mid-cycle where outputs are settled
  always @(negedge clock) begin
    if (started === 1'b1 && done !== 1'b1) lat++;
    if (inval === 1'b1) n_inval++;
    if (tx_up[1] === 1'b1) n_tx++;
    if (act_rst[0] === 1'b1) act_seen = 1'b1;
  end
  // Verdict and end of run
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock) req.penable <= 1'b1;
    // Answer is taken at the rising edge where pready stands high
    do @(posedge clock); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) failures++;
    rq = prdata;
    er = pslverr;
    req <= '0;
  endtask : apb
  // Start a change, try a write while busy, poll and clear the flags
  // No-action changes leave the full link retrain to software afterwards
  task automatic chg(input logic [1:0] md, pt, input logic [4:0] dv, input logic ac,
                     input logic [1:0] sl);
    int n;
    n = 0;
    lat = 0;
    apb(1'b1, 8'h00, {18'h0_0000, sl, 2'h0, ac, dv, pt, md});
    apb(1'b1, 8'h00, 32'h0000_0000);
    do apb(1'b0, 8'h04, 32'h0000_0000); while (rq[1] !== 1'b1 && ++n < 40);
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CK("status", 32'h0000_0003, rq & 32'h0000_0007)
    apb(1'b1, 8'h04, 32'h0000_0003);
  endtask : chg
  // One-cycle receiver exit on the given ports
  task automatic pulse(input logic [3:0] m);
    @(posedge clock) rx_exit <= m;
    @(posedge clock) rx_exit <= 4'h0;
    repeat (3) @(negedge clock);
  endtask : pulse
  // Cut a hung run short
  initial begin
    #2_000_000;
    failures++;
    conclude();
  end
  // Main sequence
  initial begin
    req = '0;
    hot_req = 4'h0;
    rx_exit = 4'h0;
    rst_n = 1'b0;
    act_seen = 1'b0;
    {failures, checks_done, n_inval, n_tx} = '0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b1, 8'h14, 32'h0000_3001);
    `CK("slverr", 1'b1, er)
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CK("status idle", 32'h0000_0000, rq)
    chg(2'h1, 2'h1, 5'h03, 1'b1, 2'h0);
    lat_r = lat;
    `CK("action reset", 1'b1, act_seen)
    apb(1'b0, 8'h00, 32'h0000_0000);
    `CK("busy ignore", 32'h0000_0235, rq)
    chg(2'h2, 2'h1, 5'h05, 1'b0, 2'h1);
    `CK("latency gap", 25 - 20, lat_r - lat)
    `CK("members", 12'h213, {has_up, up, att})
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CK("port info", 10'h325, rq[9:0])
    pulse(4'h2);
    `CK("l0s exit", 1, n_tx)
    pulse(4'h4);
    `CK("l0s outsider", 1, n_tx)
    apb(1'b1, 8'h0C, 32'h0000_0002);
    repeat (2) @(negedge clock);
    `CK("below only", 8'h02, {p_sec, below})
    @(posedge clock) hot_req <= 4'h1;
    apb(1'b1, 8'h0C, 32'h0000_0003);
    repeat (2) @(negedge clock);
    `CK("resets", 20'h2_2222, {p_hot, hot, p_sec, sec, below})
    chg(2'h0, 2'h1, 5'h05, 1'b0, 2'h1);
    `CK("inval count", 1, n_inval)
    `CK("inval port", 2'h1, inval_port)
    `CK("inval part", 2'h1, inval_part)
    `CK("left resets", 20'h2_0200, {p_hot, hot, p_sec, sec, below})
    pulse(4'h2);
    `CK("l0s removed", 1, n_tx)
    chg(2'h1, 2'h1, 5'h07, 1'b0, 2'h0);
    `CK("renumber", 2, n_inval)
    `CK("rejoin", 12'h211, {has_up, up, att})
    chg(2'h0, 2'h1, 5'h07, 1'b0, 2'h0);
    `CK("no upstream", 12'h000, {has_up, p_hot, p_sec})
    conclude();
  end
endmodule : pmcs_tb_top
